// ---- hw/ssei_prog_timer.sv ----
// ssei_prog_timer: counts the self-timed programming interval
// assumes start is a one-cycle pulse that only comes while idle
`timescale 1ns/1ps
module ssei_prog_timer #(
	parameter int CYCLES = 100000
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	output logic done
);
	logic [31:0] cnt_r; // cycles spent so far
	logic run_r; // interval in progress
	wire logic atEnd = (cnt_r == 32'(CYCLES - 1));

	// done pulses on the last cycle of the interval
	assign done = run_r && atEnd;

	// counter restarts on every start pulse
	always_ff @(posedge clk) begin
		if (rst) begin
			run_r <= 1'b0;
			cnt_r <= 32'h0;
		end else if (start) begin
			run_r <= 1'b1;
			cnt_r <= 32'h0;
		end else if (run_r) begin
			run_r <= !atEnd;
			cnt_r <= cnt_r + 32'h1;
		end
	end
endmodule

// ---- hw/ssei_sync.sv ----
// ssei_sync: two-stage level synchroniser, one per bit of a bus
// assumes each bit is a level that is stable for several destination clocks
`timescale 1ns/1ps
module ssei_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r; // first stage, read only by the second

	// no reset here: the chain flushes within two clocks of a held reset
	always_ff @(posedge clk) begin
		meta_r <= d;
		q <= meta_r;
	end
endmodule

// ---- hw/ssei_top.sv ----
// ssei_top: serial eeprom slave front end, write protection and self-timed programming
// assumes the master drives sck, csN, mosi, holdN; sck may stop between frames
// Operation
// - works in clock mode 0 and 3 unconfigured
// - array of 8192 bytes, 32-byte pages
// - single byte or page write up to 32
// - partial page keeps other bytes unchanged
// - protect upper quarter, half or whole array
// - programming self-timed, done within 5 ms
// - ignore commands in reset, then standby
// - reset reasserted abandons activity to standby
// - frame end enters standby after programming
// - every field travels most significant bit first
// - first byte of frame is the op-code
// - data output floats in standby
// - sample on rising edge, drive on falling
// - protect pin low plus enable locks status
// - suspend freezes sequence, resume continues it
// - suspend tied high means no suspension
// - op-code encodings, sixteen-bit array addresses
// - status byte: busy, latch, protect, enable
// - write latch cleared at reset and completions
// - while busy only status read accepted
`timescale 1ns/1ps
module ssei_top
	import ssei_pkg::*;
#(
	parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
	input wire logic mclk, // system clock
	input wire logic rst, // synchronous, active high power-on reset
	input wire logic sck, // serial clock from the master
	input wire logic csN, // frame select
	input wire logic mosi, // serial data in
	output logic miso, // serial data out
	output logic misoOe, // output enable of miso
	input wire logic wpN, // protect pin
	input wire logic holdN, // suspend pin, stable around sck edges
	output logic progBusy // programming in progress
);
	// system clock side declarations
	logic linkRst_r; // registered reset that clears the link side
	logic [7:0] mem_r [MEM_BYTES]; // array storage, never reset
	logic wel_r; // write enable latch
	logic [1:0] bp_r; // block protect level
	logic hpe_r; // hw_protect_enable
	ssei_exec_t exSt_r; // programming state
	logic seen_r; // last frame toggle acted upon
	logic csPrev_r; // previous synchronised select
	logic progIsSt_r; // current job is a status write
	logic [7:0] progSt_r; // status byte being programmed
	logic [PBASE_W-1:0] progPage_r; // page being programmed
	logic [7:0] progData_r [PAGE_BYTES]; // page snapshot
	logic [PAGE_BYTES-1:0] progMask_r; // bytes of the snapshot to program
	logic [31:0] busyLen_r; // helper: cycles spent busy
	logic [2:0] sysSync; // synchronised csN, toggle, wpN
	logic progDone; // end of programming interval

	// link side declarations
	ssei_phase_t phase_r; // where the frame stands
	ssei_phase_t phase_nxt;
	logic [2:0] bitCnt_r; // bit inside the current byte
	logic [7:0] shift_r; // received bits
	logic adrHi_r; // first address byte taken
	logic [ADDR_W-1:0] rdAddr_r; // running address
	logic [PAGE_W-1:0] wrIdx_r; // running index inside the page
	logic inFrame_r; // an edge was seen in this frame
	logic frameTog_r; // flips once per frame
	ssei_frame_t fr_r; // frame result
	logic [7:0] pageData_r [PAGE_BYTES]; // page write buffer
	logic [PAGE_BYTES-1:0] pageMask_r; // bytes received in this frame
	logic so_r; // output bit
	logic outEn_r; // output phase started
	logic [7:0] outLatch_r; // byte being shifted out
	logic busyS; // programming flag seen from the link side
	logic [7:0] statusByte; // status as read

	// synchronisers
	ssei_sync #(.W(3)) u_sysSync (
		.clk(mclk),
		.d({csN, frameTog_r, wpN}),
		.q(sysSync)
	);
	ssei_sync #(.W(1)) u_linkSync (
		.clk(sck),
		.d(progBusy),
		.q(busyS)
	);

	// link side decode
	wire logic [7:0] bitIn = {shift_r[6:0], mosi}; // byte completing on this edge
	wire logic byteEnd = (bitCnt_r == 3'h7);
	wire logic [2:0] opLow = bitIn[2:0];
	wire logic opKnown = (opLow == OP_SETWL) || (opLow == OP_CLRWL) || (opLow == OP_RDST) ||
		(opLow == OP_WRST) || (opLow == OP_RDARR) || (opLow == OP_WRARR);
	wire logic opValid = (bitIn[7:4] == OP_UPPER) && opKnown && (!busyS || opLow == OP_RDST);
	wire logic advance = holdN && !csN;
	wire logic isRead = (fr_r.cmd == OP_RDST) || (fr_r.cmd == OP_RDARR);
	wire logic rdPhase = (phase_r == PH_DAT) && isRead;
	wire logic datWr = (phase_r == PH_DAT) && (fr_r.cmd == OP_WRARR);
	wire logic [7:0] memRd = mem_r[rdAddr_r]; // stable: array only changes while reads are refused
	wire logic [7:0] outByte = (fr_r.cmd == OP_RDST) ? statusByte : memRd;

	// status byte; bits 4 to 6 read zero, all ones while busy
	always_comb begin
		statusByte = 8'h00;
		statusByte[ST_WEL] = wel_r;
		statusByte[ST_BP_LSB] = bp_r[0];
		statusByte[ST_BP_MSB] = bp_r[1];
		statusByte[ST_HPE] = hpe_r;
		if (busyS) begin
			statusByte = ST_BUSY_READ;
		end
	end

	// next phase at the end of each byte
	always_comb begin
		phase_nxt = phase_r;
		case (phase_r)
			PH_OPC: begin
				if (!opValid) begin
					phase_nxt = PH_IGN;
				end else if (opLow == OP_RDARR || opLow == OP_WRARR) begin
					phase_nxt = PH_ADR;
				end else if (opLow == OP_RDST || opLow == OP_WRST) begin
					phase_nxt = PH_DAT;
				end else begin
					phase_nxt = PH_IGN;
				end
			end
			PH_ADR: phase_nxt = adrHi_r ? PH_DAT : PH_ADR;
			PH_DAT: phase_nxt = PH_DAT;
			PH_IGN: phase_nxt = PH_IGN;
			default: phase_nxt = PH_IGN;
		endcase
	end

	// bit engine: rising edges sample, select high clears it
	always_ff @(posedge sck or posedge csN or posedge linkRst_r) begin
		if (csN || linkRst_r) begin
			phase_r <= PH_OPC;
			bitCnt_r <= 3'h0;
			shift_r <= 8'h00;
			adrHi_r <= 1'b0;
			rdAddr_r <= '0;
			wrIdx_r <= '0;
			inFrame_r <= 1'b0;
		end else if (holdN) begin
			inFrame_r <= 1'b1;
			shift_r <= bitIn;
			bitCnt_r <= bitCnt_r + 3'h1;
			if (byteEnd) begin
				phase_r <= phase_nxt;
				if (phase_r == PH_ADR) begin
					adrHi_r <= 1'b1;
					if (adrHi_r) begin
						rdAddr_r[7:0] <= bitIn;
						wrIdx_r <= bitIn[PAGE_W-1:0];
					end else begin
						rdAddr_r[ADDR_W-1:8] <= bitIn[ADDR_W-9:0]; // upper three address bits ignored
					end
				end else if (rdPhase) begin
					rdAddr_r <= rdAddr_r + 1'b1;
				end else if (datWr) begin
					wrIdx_r <= wrIdx_r + 1'b1;
				end
			end
		end
	end

	// frame result survives select high until the system side has read it
	always_ff @(posedge sck or posedge linkRst_r) begin
		if (linkRst_r) begin
			frameTog_r <= 1'b0;
			fr_r <= '0;
			pageMask_r <= '0;
		end else if (advance) begin
			if (!inFrame_r) begin
				frameTog_r <= ~frameTog_r;
				fr_r <= '0;
				pageMask_r <= '0;
			end else if (byteEnd) begin
				if (phase_r == PH_OPC) begin
					fr_r.cmd <= opLow;
					fr_r.opOk <= opValid;
				end
				if (phase_r == PH_ADR && adrHi_r) begin
					fr_r.addr <= {rdAddr_r[ADDR_W-1:8], bitIn};
				end
				if (phase_r == PH_DAT && fr_r.cmd == OP_WRST && !fr_r.hasData) begin
					fr_r.stByte <= bitIn;
					fr_r.hasData <= 1'b1;
				end
				if (datWr) begin
					pageMask_r[wrIdx_r] <= 1'b1;
					fr_r.hasData <= 1'b1;
				end
			end
		end
	end

	// page buffer data, plain storage
	always_ff @(posedge sck) begin
		if (advance && inFrame_r && byteEnd && datWr) begin
			pageData_r[wrIdx_r] <= bitIn;
		end
	end

	// output shifter: falling edges drive the next bit
	always_ff @(negedge sck or posedge csN or posedge linkRst_r) begin
		if (csN || linkRst_r) begin
			so_r <= 1'b0;
			outEn_r <= 1'b0;
			outLatch_r <= 8'h00;
		end else if (holdN && rdPhase) begin
			outEn_r <= 1'b1;
			if (bitCnt_r == 3'h0) begin
				so_r <= outByte[7];
				outLatch_r <= outByte;
			end else begin
				so_r <= outLatch_r[3'h7 - bitCnt_r];
			end
		end
	end

	// output floats unless selected, not suspended and in a read phase
	assign misoOe = !csN && holdN && outEn_r;
	assign miso = so_r;

	// system clock side
	wire logic csS = sysSync[2];
	wire logic togS = sysSync[1];
	wire logic wpS = sysSync[0];
	wire logic csRise = csS && !csPrev_r;
	wire logic newFrame = csRise && (togS != seen_r); // frames with no edge are ignored
	wire logic busyW = (exSt_r == EX_PROG);
	wire logic execGo = newFrame && !busyW && fr_r.opOk;
	wire logic hwProt = !wpS && hpe_r;
	wire logic protPage = ssei_is_prot(bp_r, fr_r.addr);
	wire logic startWr = execGo && fr_r.cmd == OP_WRARR && wel_r && fr_r.hasData && !protPage;
	wire logic startSt = execGo && fr_r.cmd == OP_WRST && wel_r && fr_r.hasData && !hwProt;
	wire logic setWel = execGo && fr_r.cmd == OP_SETWL;
	wire logic clrWel = execGo && fr_r.cmd == OP_CLRWL;

	assign progBusy = busyW;

	ssei_prog_timer #(.CYCLES(PROG_CYCLES)) u_timer (
		.clk(mclk),
		.rst(rst),
		.start(startWr || startSt),
		.done(progDone)
	);

	// reset fan-out and frame bookkeeping
	always_ff @(posedge mclk) begin
		linkRst_r <= rst;
		csPrev_r <= rst ? 1'b1 : csS;
		// follow the toggle until the link side reset has flushed through the synchroniser
		seen_r <= (rst || linkRst_r) ? togS : (newFrame ? togS : seen_r);
		busyLen_r <= (rst || !busyW) ? 32'h0 : busyLen_r + 32'h1;
	end

	// programming state; reset abandons a running cycle
	always_ff @(posedge mclk) begin
		if (rst) begin
			exSt_r <= EX_IDLE;
		end else if (progDone) begin
			exSt_r <= EX_IDLE;
		end else if (startWr || startSt) begin
			exSt_r <= EX_PROG;
		end
	end

	// write latch and protect bits; status job takes effect at completion
	always_ff @(posedge mclk) begin
		if (rst) begin
			wel_r <= 1'b0;
			bp_r <= BP_RESET;
			hpe_r <= 1'b0;
		end else if (progDone) begin
			wel_r <= 1'b0;
			if (progIsSt_r) begin
				bp_r <= {progSt_r[ST_BP_MSB], progSt_r[ST_BP_LSB]};
				hpe_r <= progSt_r[ST_HPE];
			end
		end else if (setWel) begin
			wel_r <= 1'b1;
		end else if (clrWel) begin
			wel_r <= 1'b0;
		end
	end

	// snapshot the page so later frames cannot disturb a running job
	always_ff @(posedge mclk) begin
		if (startWr || startSt) begin
			progIsSt_r <= startSt;
			progSt_r <= fr_r.stByte;
			progPage_r <= fr_r.addr[ADDR_W-1:PAGE_W];
			progData_r <= pageData_r;
			progMask_r <= pageMask_r;
		end
	end

	// array update at the end of the interval, received bytes only
	always_ff @(posedge mclk) begin
		if (progDone && !progIsSt_r) begin
			for (int i = 0; i < PAGE_BYTES; i++) begin
				if (progMask_r[i]) begin
					mem_r[{progPage_r, PAGE_W'(i)}] <= progData_r[i];
				end
			end
		end
	end

	// assertions
	sequence sWrLaunch;
		startWr;
	endsequence

	sequence sProgEnd;
		progDone ##1 !busyW;
	endsequence

	a_reset_standby: assert property (@(posedge mclk) disable iff (rst)
		$past(rst) |-> !busyW && !wel_r) else $error("not in standby after reset");
	a_reset_abort: assert property (@(posedge mclk) disable iff (rst)
		$past(rst) |-> busyLen_r == 32'h0) else $error("programming survived reset");
	a_done_owned: assert property (@(posedge mclk) disable iff (rst)
		progDone |-> busyW) else $error("programming end without a running job");
	a_prog_bound: assert property (@(posedge mclk) disable iff (rst)
		busyLen_r <= 32'(PROG_CYCLES)) else $error("programming ran too long");
	a_wr_launch: assert property (@(posedge mclk) disable iff (rst)
		sWrLaunch |=> busyW ##0 $past(wel_r)) else $error("write did not start programming");
	a_done_standby: assert property (@(posedge mclk) disable iff (rst)
		progDone |-> sProgEnd ##0 !wel_r) else $error("no standby after programming");
	a_busy_ignore: assert property (@(posedge mclk) disable iff (rst)
		busyW && newFrame && !progDone |=> $stable(wel_r) && busyW) else $error("command taken while busy");
	a_hw_lock: assert property (@(posedge mclk) disable iff (rst)
		newFrame && !busyW && fr_r.cmd == OP_WRST && hwProt |=> !busyW) else $error("status write passed lock");
	a_block_prot: assert property (@(posedge mclk) disable iff (rst)
		newFrame && !busyW && fr_r.cmd == OP_WRARR && protPage |=> !busyW) else $error("protected page written");
	a_hold_freeze: assert property (@(posedge sck) disable iff (linkRst_r || csN)
		!holdN && inFrame_r |=> $stable(bitCnt_r) && $stable(shift_r)) else $error("engine moved in suspend");
endmodule

// ---- pkg/ssei_pkg.sv ----
// ssei_pkg: constants, types and helpers of the serial eeprom front end
// assumes a 20 MHz system clock and a slave link driven by an external master
package ssei_pkg;

	// array geometry
	localparam int MEM_BYTES = 8192; // bytes in the array
	localparam int PAGE_BYTES = 32; // bytes in one programming page
	localparam int ADDR_W = 13; // byte address width
	localparam int PAGE_W = 5; // address bits inside a page
	localparam int PBASE_W = ADDR_W - PAGE_W; // page number width

	// op-code fields: upper nibble must be zero, bit 3 is ignored
	localparam logic [3:0] OP_UPPER = 4'h0;
	localparam logic [2:0] OP_SETWL = 3'h6; // set_write_latch_cmd
	localparam logic [2:0] OP_CLRWL = 3'h4; // clear_write_latch_cmd
	localparam logic [2:0] OP_RDST = 3'h5; // read_status_cmd
	localparam logic [2:0] OP_WRST = 3'h1; // write_status_cmd
	localparam logic [2:0] OP_RDARR = 3'h3; // read array
	localparam logic [2:0] OP_WRARR = 3'h2; // write array

	// status byte layout
	localparam int ST_BUSY = 0;
	localparam int ST_WEL = 1;
	localparam int ST_BP_LSB = 2; // block_protect_lsb
	localparam int ST_BP_MSB = 3; // block_protect_msb
	localparam int ST_HPE = 7; // hw_protect_enable
	localparam logic [7:0] ST_BUSY_READ = 8'hFF; // all ones while programming
	localparam logic [1:0] BP_RESET = 2'h0; // factory protect level
	localparam logic BIT_LAST = 1'b1;

	// protect levels and lowest protected address of each
	localparam logic [1:0] BP_NONE = 2'h0;
	localparam logic [1:0] BP_QUARTER = 2'h1;
	localparam logic [1:0] BP_HALF = 2'h2;
	localparam logic [ADDR_W-1:0] PROT_QUARTER = 13'h1800;
	localparam logic [ADDR_W-1:0] PROT_HALF = 13'h1000;

	// self-timed programming: longest time, rounded down to cycles
	localparam int MCLK_HZ = 20_000_000;
	localparam int PROG_TIME_NS = 5_000_000;
	localparam int PROG_CYCLES_DEF = (PROG_TIME_NS / 1000) * (MCLK_HZ / 1000) / 1000;

	// link engine phase, one-hot
	typedef enum logic [3:0] {
		PH_OPC = 4'h1,
		PH_ADR = 4'h2,
		PH_DAT = 4'h4,
		PH_IGN = 4'h8
	} ssei_phase_t;

	// programming engine state, one-hot
	typedef enum logic [1:0] {
		EX_IDLE = 2'h1,
		EX_PROG = 2'h2
	} ssei_exec_t;

	// what one frame left behind for the system-clock side
	typedef struct packed {
		logic [2:0] cmd; // op-code low bits
		logic opOk; // op-code decoded as accepted
		logic hasData; // at least one data byte completed
		logic [ADDR_W-1:0] addr; // start address of an array command
		logic [7:0] stByte; // first status byte written
	} ssei_frame_t;

	// true when an address falls inside the protected block
	function automatic logic ssei_is_prot(input logic [1:0] bp, input logic [ADDR_W-1:0] a);
		logic hit;
		hit = 1'b1;
		case (bp)
			BP_NONE: hit = 1'b0;
			BP_QUARTER: hit = (a >= PROT_QUARTER);
			BP_HALF: hit = (a >= PROT_HALF);
			default: hit = 1'b1;
		endcase
		return hit;
	endfunction

endpackage

// ---- verif/ssei_master_model.sv ----
// ssei_master_model: behavioural serial link master with an optional suspend
// assumes the bench calls its tasks one at a time and reads slave data through a pulled-up wire
`timescale 1ns/1ps
module ssei_master_model (
	output logic sck, // serial clock, stands still between frames
	output logic csN, // frame select
	output logic mosi, // serial data to the slave
	output logic holdN, // suspend request
	input wire logic misoW // resolved serial data from the slave
);
	logic mode3 = 1'b0; // idle clock level: low for mode 0, high for mode 3
	// idle levels, suspend off unless a test asks for it
	initial begin
		sck = 1'b0;
		csN = 1'b1;
		mosi = 1'b0;
		holdN = 1'b1;
	end
	// open a frame with a high to low select edge, clock parked at its idle level
	task automatic start();
		sck = mode3;
		#37 csN = 1'b0;
		#62;
	endtask
	// one byte, most significant bit first; data set while clock low, sampled at the rise
	task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			#62 sck = 1'b0;
			mosi = tx[i];
			#63 sck = 1'b1;
			rx[i] = misoW;
		end
	endtask
	// close after the final rise and before any further one
	task automatic stop();
		#62 sck = mode3;
		#62 csN = 1'b1;
		mosi = ~mosi; // a released line must not show the last bit
		#400;
	endtask
	// suspend only while the clock is low, then send pulses that must be ignored
	task automatic pause(input int n);
		#62 sck = 1'b0;
		#20 holdN = 1'b0;
		repeat (n) begin
			#62 sck = 1'b1;
			mosi = ~mosi;
			#63 sck = 1'b0;
		end
		#40;
	endtask
	// leave suspend with the clock still low
	task automatic resume();
		holdN = 1'b1;
		#20;
	endtask
endmodule

// ---- verif/testbench.sv ----
// testbench: self-checking sequences of serial frames against the eeprom front end
// assumes the master model owns the link pins and the bench owns mclk, rst and wpN
`timescale 1ns/1ps
module testbench;
	import ssei_pkg::*;
	localparam int PCYC = 200; // short programming interval, still longer than one status frame
	logic mclk = 1'b0; // system clock, 50 ns
	logic rst = 1'b1; // power-on reset
	logic wpN = 1'b1; // protect pin
	logic sck;
	logic csN;
	logic mosi;
	logic holdN;
	logic miso;
	logic misoOe;
	logic progBusy;
	wire misoW = misoOe ? miso : 1'b1; // pull-up when the slave floats its output
	int n_fail = 0;
	int n_compared = 0;
	int cyc = 0; // watchdog count of mclk cycles
	logic [7:0] page [0:31]; // expected contents of page 0x0100
	logic [7:0] rx;
	logic [7:0] q [$];
	always #25 mclk = ~mclk;
	ssei_top #(.PROG_CYCLES(PCYC)) DUT (.mclk(mclk), .rst(rst), .sck(sck), .csN(csN), .mosi(mosi),
		.miso(miso), .misoOe(misoOe), .wpN(wpN), .holdN(holdN), .progBusy(progBusy));
	ssei_master_model master (.sck(sck), .csN(csN), .mosi(mosi), .holdN(holdN), .misoW(misoW));
	// compare and count
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// counts, verdict and end of run
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// watchdog: a hang counts as a mismatch
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 40000) begin
			n_fail++;
			stop_test();
		end
	end
	// single op-code frame; callers pass defined op-codes only
	task automatic cmd1(input logic [7:0] op);
		master.start();
		master.xb(op, rx);
		master.stop();
	endtask
	// status read frame
	task automatic rdst(output logic [7:0] st);
		master.start();
		master.xb(8'h05, rx);
		master.xb(8'h00, st);
		master.stop();
	endtask
	// bounded wait for the end of programming
	task automatic waitIdle();
		for (int k = 0; k < PCYC + 40 && progBusy !== 1'b0; k++) begin
			@(posedge mclk);
		end
		chk("progBusy end", {7'h00, progBusy}, 8'h00);
	endtask
	// array write; exp tells whether programming must start
	task automatic wrArr(input logic [15:0] a, input logic latch, input logic exp);
		if (latch) begin
			cmd1(8'h06);
		end
		master.start();
		master.xb(8'h02, rx);
		master.xb(a[15:8], rx);
		master.xb(a[7:0], rx);
		foreach (q[i]) begin
			master.xb(q[i], rx);
		end
		master.stop();
		chk("progBusy start", {7'h00, progBusy}, {7'h00, exp});
	endtask
	// status write with latch set first
	task automatic wrSt(input logic [7:0] v, input logic exp);
		cmd1(8'h06);
		master.start();
		master.xb(8'h01, rx);
		master.xb(v, rx);
		master.stop();
		chk("status write start", {7'h00, progBusy}, {7'h00, exp});
		waitIdle();
	endtask
	// read n bytes inside page 0x0100 and compare
	task automatic rdChk(input logic [15:0] a, input int n);
		master.start();
		master.xb(8'h03, rx);
		master.xb(a[15:8], rx);
		master.xb(a[7:0], rx);
		for (int i = 0; i < n; i++) begin
			master.xb(8'h00, rx);
			chk("read data", rx, page[(a[4:0] + i) % 32]);
		end
		master.stop();
	endtask
	initial begin
		repeat (16) @(posedge mclk);
		#2 rst = 1'b0;
		repeat (4) @(posedge mclk);
		chk("misoOe standby", {7'h00, misoOe}, 8'h00);
		rdst(rx);
		chk("status after reset", rx, 8'h00);
		cmd1(8'h0E);
		rdst(rx);
		chk("latch set", rx, 8'h02);
		cmd1(8'h0C);
		rdst(rx);
		chk("latch cleared", rx, 8'h00);
		$display("test latch done");
		q = {};
		for (int i = 0; i < 32; i++) begin
			page[i] = 8'(i) ^ 8'h5A;
			q.push_back(page[i]);
		end
		wrArr(16'h0100, 1'b0, 1'b0);
		wrArr(16'h0100, 1'b1, 1'b1);
		rdst(rx);
		chk("status busy", rx, 8'hFF);
		cmd1(8'h06);
		waitIdle();
		rdst(rx);
		chk("latch after write", rx, 8'h00);
		q = {8'hA0, 8'hA1, 8'hA2};
		page[30] = 8'hA0;
		page[31] = 8'hA1;
		page[0] = 8'hA2;
		wrArr(16'h011E, 1'b1, 1'b1);
		waitIdle();
		rdChk(16'h0100, 32);
		master.mode3 = 1'b1;
		rdChk(16'h0108, 4);
		master.mode3 = 1'b0;
		$display("test page write done");
		q = {8'h3C};
		for (int bp = 1; bp < 4; bp++) begin
			wrSt({4'h0, 2'(bp), 2'h0}, 1'b1);
			rdst(rx);
			chk("protect level", rx, {4'h0, 2'(bp), 2'h0});
			wrArr(16'h1800, 1'b1, 1'b0);
			wrArr(16'h1000, 1'b1, bp < 2);
			waitIdle();
			wrArr(16'h0000, 1'b1, bp < 3);
			waitIdle();
		end
		wrSt(8'h00, 1'b1);
		$display("test block protect done");
		wrSt(8'h84, 1'b1);
		@(posedge mclk);
		#2 wpN = 1'b0;
		repeat (4) @(posedge mclk);
		wrSt(8'h00, 1'b0);
		rdst(rx);
		chk("locked status", rx, 8'h86);
		@(posedge mclk);
		#2 wpN = 1'b1;
		repeat (4) @(posedge mclk);
		wrSt(8'h00, 1'b1);
		rdst(rx);
		chk("unlocked status", rx, 8'h00);
		$display("test hardware protect done");
		master.start();
		master.xb(8'h03, rx);
		master.xb(8'h01, rx);
		master.xb(8'h08, rx);
		master.pause(3);
		chk("misoOe suspended", {7'h00, misoOe}, 8'h00);
		master.resume();
		master.xb(8'h00, rx);
		chk("read after resume", rx, page[8]);
		chk("misoOe reading", {7'h00, misoOe}, 8'h01);
		master.stop();
		chk("misoOe after frame", {7'h00, misoOe}, 8'h00);
		$display("test suspend done");
		q = {8'hEE};
		wrArr(16'h0100, 1'b1, 1'b1);
		@(posedge mclk);
		#2 rst = 1'b1;
		repeat (4) @(posedge mclk);
		chk("busy in reset", {7'h00, progBusy}, 8'h00);
		#2 rst = 1'b0;
		repeat (4) @(posedge mclk);
		rdst(rx);
		chk("status after abort", rx, 8'h00);
		rdChk(16'h0100, 1);
		$display("test reset abort done");
		stop_test();
	end
endmodule
